// File: common/sfc_pkg.sv
package sfc_pkg;

  localparam int unsigned BYTE_W       = 8;
  localparam int unsigned BIT_CNT_W    = 3;
  localparam logic [2:0]  BIT_LAST     = 3'h7;
  localparam logic [2:0]  BIT_FIRST    = 3'h0;

  // Only the low 18 address bits are kept; the first six shifted in fall off the top
  localparam int unsigned ADDR_W         = 18;
  localparam int unsigned ADDR_CNT_W     = 2;
  localparam logic [1:0]  ADDR_BYTE_LAST = 2'h2;
  localparam logic [1:0]  ADDR_BYTE_0    = 2'h0;

  localparam int unsigned WR_WORD_W  = ADDR_W + BYTE_W;
  localparam int unsigned FIFO_DEPTH = 8;

  localparam logic [7:0] OP_LATCH_SET    = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR  = 8'h04;
  localparam logic [7:0] OP_STATUS_READ  = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_MEM_READ     = 8'h03;
  localparam logic [7:0] OP_FAST_READ    = 8'h0B;
  localparam logic [7:0] OP_MEM_WRITE    = 8'h02;
  localparam logic [7:0] OP_SLEEP        = 8'hB9;
  localparam logic [7:0] OP_IDENT_READ   = 8'h9F;

  // Status byte: bit 7 protect enable, bit 6 fixed one, bits 3:2 block protect, bit 1 write enable flag
  localparam int unsigned SR_WE_FLAG_BIT = 1;
  localparam logic [7:0]  SR_RESET       = 8'h40;
  localparam logic [7:0]  SR_WR_MASK     = 8'h8C;

  // Synchroniser reset levels for {cs_b, sck, si}: deselected, clock low
  localparam logic [2:0] SYNC_RST = 3'h4;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_OPCODE,
    ST_ADDR,
    ST_DUMMY,
    ST_WDATA,
    ST_RDATA,
    ST_SRWR,
    ST_SROUT,
    ST_IGNORE
  } sfc_state_type;

  typedef enum logic [1:0] {
    KIND_READ,
    KIND_FAST,
    KIND_WRITE
  } sfc_kind_type;

endpackage : sfc_pkg

// File: common/sfc_stream_if.sv
`timescale 1ns/1ns
interface sfc_stream_if #(
  parameter int unsigned WIDTH = sfc_pkg::WR_WORD_W
) ();
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sfc_stream_if

// File: design/sfc_sync.sv
`timescale 1ns/1ns
module sfc_sync #(
  parameter int unsigned      WIDTH   = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_b,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  import sfc_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sfc_sync_state_type;

  sfc_sync_state_type st_ff;
  sfc_sync_state_type nxt_st;

  // First stage feeds only the second stage
  always_comb
  begin
    nxt_st    = st_ff;
    nxt_st.s1 = i_async;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      st_ff.s1 <= RST_VAL;
      st_ff.s2 <= RST_VAL;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign o_sync = st_ff.s2;

endmodule : sfc_sync

// File: design/sfc_fifo.sv
`timescale 1ns/1ns
module sfc_fifo #(
  parameter int unsigned WIDTH = 26,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_b,
  sfc_stream_if.snk             snk,
  output logic                  o_valid,
  output logic      [WIDTH-1:0] o_data,
  input  wire logic             i_ready
);
  import sfc_pkg::*;

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr_ptr;
    logic [PTR_W-1:0]            rd_ptr;
    logic [CNT_W-1:0]            cnt;
    logic                        out_valid;
    logic [WIDTH-1:0]            out_data;
  } sfc_fifo_state_type;

  sfc_fifo_state_type st_ff;
  sfc_fifo_state_type nxt_st;
  logic               push;
  logic               pop;

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    if (p == PTR_W'(DEPTH - 1))
      ptr_inc = '0;
    else
      ptr_inc = p + 1'b1;
  endfunction : ptr_inc

  assign snk.ready = (st_ff.cnt != CNT_W'(DEPTH));
  assign push      = snk.valid && snk.ready;
  // Output stage refills whenever it is empty or being taken, so the drain side sees flop outputs
  assign pop       = (st_ff.cnt != '0) && (!st_ff.out_valid || i_ready);

  always_comb
  begin
    nxt_st = st_ff;
    if (st_ff.out_valid && i_ready)
      nxt_st.out_valid = 1'b0;
    if (pop)
    begin
      nxt_st.out_data  = st_ff.mem[st_ff.rd_ptr];
      nxt_st.out_valid = 1'b1;
      nxt_st.rd_ptr    = ptr_inc(st_ff.rd_ptr);
    end
    if (push)
    begin
      nxt_st.mem[st_ff.wr_ptr] = snk.data;
      nxt_st.wr_ptr            = ptr_inc(st_ff.wr_ptr);
    end
    case ({push, pop})
      2'h2:    nxt_st.cnt = st_ff.cnt + 1'b1;
      2'h1:    nxt_st.cnt = st_ff.cnt - 1'b1;
      default: nxt_st.cnt = st_ff.cnt;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign o_valid = st_ff.out_valid;
  assign o_data  = st_ff.out_data;

endmodule : sfc_fifo

// File: design/sfc_front.sv
`timescale 1ns/1ns
// Operation
// - Target only; serial clock supplied from outside
// - Clock level at select fall picks mode
// - Sample input on rising edges after select
// - Output changes only on falling edges
// - All bytes shift most significant bit first
// - First byte is opcode; one per select
// - Deselected: ignore input, output tristated
// - Three address bytes; keep low 18 bits
// - Decode latch set and latch clear opcodes
// - Eight-bit status register; read and write opcodes
// - Decode read, fast read, write opcodes
// - Nine opcodes, including sleep and ident
// - Unknown opcode: no action until reselect
// - Write enable latch cleared at reset
// - No write while latch is clear
// - Latch set sets flag; status write leaves it
// - Select rise ends clear/write: latch cleared
// - Writes finish in transfer; never busy
// - Status read shifts out status byte
// - Select high: standby, inputs ignored
module sfc_front (
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_rst_b,
  input  wire logic                          i_cs_b,
  input  wire logic                          i_sck,
  input  wire logic                          i_si,
  output logic                               o_so,
  output logic                               o_so_oe,
  output logic                               o_spi_mode3,
  output logic                               o_sleep,
  output logic      [sfc_pkg::BYTE_W-1:0]    o_status,
  output logic      [sfc_pkg::ADDR_W-1:0]    o_rd_addr,
  input  wire logic [sfc_pkg::BYTE_W-1:0]    i_rd_data,
  output logic                               o_wr_valid,
  input  wire logic                          i_wr_ready,
  output logic      [sfc_pkg::ADDR_W-1:0]    o_wr_addr,
  output logic      [sfc_pkg::BYTE_W-1:0]    o_wr_data
);
  import sfc_pkg::*;

  typedef struct packed {
    sfc_state_type          state;
    sfc_kind_type           kind;
    logic                   cs_b_d;
    logic                   sck_d;
    logic                   mode3;
    logic [BIT_CNT_W-1:0]   bit_cnt;
    logic [BYTE_W-2:0]      rx;
    logic [ADDR_CNT_W-1:0]  addr_cnt;
    logic [ADDR_W-1:0]      addr;
    logic [BYTE_W-1:0]      sr;
    logic                   pend_clr;
    logic                   sleep;
    logic [BIT_CNT_W-1:0]   tx_cnt;
    logic [BYTE_W-1:0]      tx;
    logic                   so;
    logic                   so_oe;
    logic                   push;
    logic [WR_WORD_W-1:0]   push_word;
  } sfc_front_state_type;

  sfc_front_state_type st_ff;
  sfc_front_state_type nxt_st;
  logic [2:0]          sync_q;
  logic                cs_b_s;
  logic                sck_s;
  logic                si_s;
  logic [WR_WORD_W-1:0] fifo_word;
  logic                 sel_rise;
  logic                 sel_fall;
  logic                 sck_rise;
  logic                 sck_fall;

  sfc_stream_if #(.WIDTH(WR_WORD_W)) wr_if ();

  // Pins are sampled by the system clock; the serial clock must stay below a quarter of its rate
  sfc_sync #(
    .WIDTH   (3),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_async   ({i_cs_b, i_sck, i_si}),
    .o_sync    (sync_q)
  );

  assign cs_b_s = sync_q[2];
  assign sck_s  = sync_q[1];
  assign si_s   = sync_q[0];

  // Write bytes queue here; a full queue drops the byte and holds the address
  sfc_fifo #(
    .WIDTH (WR_WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .snk       (wr_if),
    .o_valid   (o_wr_valid),
    .o_data    (fifo_word),
    .i_ready   (i_wr_ready)
  );

  assign wr_if.valid = st_ff.push;
  assign wr_if.data  = st_ff.push_word;

  // Edges are found in the same system clock as the synchronised level change, by comparing with a one-clock-old copy
  assign sel_rise = cs_b_s && !st_ff.cs_b_d;
  assign sel_fall = !cs_b_s && st_ff.cs_b_d;
  assign sck_rise = sck_s && !st_ff.sck_d;
  assign sck_fall = !sck_s && st_ff.sck_d;

  // Address counter rolls over from the top location to zero
  function automatic logic [ADDR_W-1:0] addr_next(input logic [ADDR_W-1:0] a);
    addr_next = a + 1'b1;
  endfunction : addr_next

  function automatic logic [BYTE_W-1:0] shift_up(input logic [BYTE_W-1:0] b);
    shift_up = {b[BYTE_W-2:0], 1'b0};
  endfunction : shift_up

  // Both gated writes ask the latch through this one place
  function automatic logic we_flag_of(input logic [BYTE_W-1:0] s);
    we_flag_of = s[SR_WE_FLAG_BIT];
  endfunction : we_flag_of

  // Only the writable bits take the new byte; the latch flag and fixed bits keep their value
  function automatic logic [BYTE_W-1:0] sr_merge(input logic [BYTE_W-1:0] s, input logic [BYTE_W-1:0] b);
    sr_merge = (s & ~SR_WR_MASK) | (b & SR_WR_MASK);
  endfunction : sr_merge

  // Only the two output phases ever drive the data pin
  function automatic logic out_state(input sfc_state_type s);
    out_state = (s == ST_RDATA) || (s == ST_SROUT);
  endfunction : out_state

  always_comb
  begin
    logic [BYTE_W-1:0] byte_in;
    logic [BYTE_W-1:0] out_byte;
    byte_in         = {st_ff.rx, si_s};
    out_byte        = st_ff.sr;
    nxt_st          = st_ff;
    nxt_st.cs_b_d   = cs_b_s;
    nxt_st.sck_d    = sck_s;
    nxt_st.push     = 1'b0;
    if (sel_rise)
    begin
      nxt_st.state = ST_IDLE;
      nxt_st.so_oe = 1'b0;
      if (st_ff.pend_clr)
        nxt_st.sr[SR_WE_FLAG_BIT] = 1'b0;
      nxt_st.pend_clr = 1'b0;
    end
    else if (sel_fall)
    begin
      nxt_st.mode3    = sck_s;
      nxt_st.state    = ST_OPCODE;
      nxt_st.bit_cnt  = BIT_FIRST;
      nxt_st.tx_cnt   = BIT_FIRST;
      nxt_st.addr_cnt = ADDR_BYTE_0;
      nxt_st.sleep    = 1'b0;
      nxt_st.so_oe    = 1'b0;
    end
    else if (cs_b_s)
    begin
      nxt_st.state = ST_IDLE;
    end
    else if (sck_rise)
    begin
      // Only a low-to-high change counts, so an idle-high clock in mode 3 adds no edge
      nxt_st.rx      = byte_in[BYTE_W-2:0];
      nxt_st.bit_cnt = st_ff.bit_cnt + 1'b1;
      if (st_ff.bit_cnt == BIT_LAST)
      begin
        case (st_ff.state)
          ST_OPCODE:
          begin
            nxt_st.state = ST_IGNORE;
            case (byte_in)
              OP_LATCH_SET:
                nxt_st.sr[SR_WE_FLAG_BIT] = 1'b1;
              OP_LATCH_CLEAR:
                nxt_st.pend_clr = 1'b1;
              OP_STATUS_READ:
                nxt_st.state = ST_SROUT;
              OP_STATUS_WRITE:
              begin
                nxt_st.state    = ST_SRWR;
                nxt_st.pend_clr = 1'b1;
              end
              OP_MEM_READ:
              begin
                nxt_st.state = ST_ADDR;
                nxt_st.kind  = KIND_READ;
              end
              OP_FAST_READ:
              begin
                nxt_st.state = ST_ADDR;
                nxt_st.kind  = KIND_FAST;
              end
              OP_MEM_WRITE:
              begin
                nxt_st.state    = ST_ADDR;
                nxt_st.kind     = KIND_WRITE;
                nxt_st.pend_clr = 1'b1;
              end
              OP_SLEEP:
                nxt_st.sleep = 1'b1;
              OP_IDENT_READ:
                nxt_st.state = ST_IGNORE;
              default:
                nxt_st.state = ST_IGNORE;
            endcase
          end
          ST_ADDR:
          begin
            // Shifting through an 18-bit register drops the six leading bits
            nxt_st.addr     = {st_ff.addr[ADDR_W-BYTE_W-1:0], byte_in};
            nxt_st.addr_cnt = st_ff.addr_cnt + 1'b1;
            if (st_ff.addr_cnt == ADDR_BYTE_LAST)
            begin
              case (st_ff.kind)
                KIND_READ:  nxt_st.state = ST_RDATA;
                KIND_FAST:  nxt_st.state = ST_DUMMY;
                KIND_WRITE: nxt_st.state = ST_WDATA;
                default:    nxt_st.state = ST_IGNORE;
              endcase
            end
          end
          ST_DUMMY:
            nxt_st.state = ST_RDATA;
          ST_WDATA:
          begin
            // A refused byte leaves the address where it was
            if (we_flag_of(st_ff.sr) && wr_if.ready)
            begin
              nxt_st.push      = 1'b1;
              nxt_st.push_word = {st_ff.addr, byte_in};
              nxt_st.addr      = addr_next(st_ff.addr);
            end
          end
          ST_SRWR:
          begin
            if (we_flag_of(st_ff.sr))
              nxt_st.sr = sr_merge(st_ff.sr, byte_in);
            nxt_st.state = ST_IGNORE;
          end
          default:
            nxt_st.state = st_ff.state;
        endcase
      end
    end
    else if (sck_fall && out_state(st_ff.state))
    begin
      nxt_st.so_oe = 1'b1;
      if (st_ff.tx_cnt == BIT_FIRST)
      begin
        if (st_ff.state == ST_RDATA)
        begin
          out_byte    = i_rd_data;
          nxt_st.addr = addr_next(st_ff.addr);
        end
        nxt_st.so     = out_byte[BYTE_W-1];
        nxt_st.tx     = shift_up(out_byte);
        nxt_st.tx_cnt = BIT_LAST;
      end
      else
      begin
        nxt_st.so     = st_ff.tx[BYTE_W-1];
        nxt_st.tx     = shift_up(st_ff.tx);
        nxt_st.tx_cnt = st_ff.tx_cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      st_ff        <= '0;
      st_ff.cs_b_d <= 1'b1;
      st_ff.sr     <= SR_RESET;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign o_so        = st_ff.so;
  assign o_so_oe     = st_ff.so_oe;
  assign o_spi_mode3 = st_ff.mode3;
  assign o_sleep     = st_ff.sleep;
  assign o_status    = st_ff.sr;
  assign o_rd_addr   = st_ff.addr;
  assign o_wr_addr   = fifo_word[WR_WORD_W-1:BYTE_W];
  assign o_wr_data   = fifo_word[BYTE_W-1:0];

endmodule : sfc_front

// File: testbench/sfc_front_sva.sv
`timescale 1ns/1ns
module sfc_front_sva (
  input wire logic        i_sys_clk,
  input wire logic        i_rst_b,
  input wire logic        i_cs_b,
  input wire logic        i_sck,
  input wire logic        o_so,
  input wire logic        o_so_oe,
  input wire logic        o_spi_mode3,
  input wire logic        o_sleep,
  input wire logic [7:0]  o_status,
  input wire logic        o_wr_valid,
  input wire logic        i_wr_ready,
  input wire logic [17:0] o_wr_addr,
  input wire logic [7:0]  o_wr_data
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);
  sequence sel_fall;
    $fell(i_cs_b);
  endsequence
  // Long enough for the synchroniser plus the state update
  sequence desel_held;
    i_cs_b [*6];
  endsequence
  oe_deselect_a: assert property (desel_held |-> !o_so_oe)
    else $error("output enabled while deselected");
  so_on_fall_a: assert property (o_so_oe && $past(o_so_oe) && !$stable(o_so) |-> !i_sck)
    else $error("serial output moved in a high clock phase");
  mode_catch_a: assert property (sel_fall |-> ##5 (o_spi_mode3 == i_sck))
    else $error("mode not taken from clock level");
  fixed_bits_a: assert property (o_status[6] && o_status[5:4] == 2'h0 && !o_status[0])
    else $error("fixed status bits wrong");
  prot_bits_a: assert property (!$stable(o_status & 8'h8C) |-> !i_cs_b)
    else $error("protect bits changed while deselected");
  flag_set_a: assert property ($rose(o_status[1]) |-> !i_cs_b)
    else $error("flag set while deselected");
  flag_clear_a: assert property ($fell(o_status[1]) |-> i_cs_b && $past(i_cs_b, 2))
    else $error("flag cleared away from select rise");
  sleep_clear_a: assert property (sel_fall |-> ##6 !o_sleep)
    else $error("sleep not cleared by select");
  wr_hold_a: assert property (o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable({o_wr_addr, o_wr_data}))
    else $error("queued write changed before taken");
endmodule : sfc_front_sva
bind sfc_front sfc_front_sva u_sva (
  .i_sys_clk, .i_rst_b, .i_cs_b, .i_sck, .o_so, .o_so_oe, .o_spi_mode3, .o_sleep,
  .o_status, .o_wr_valid, .i_wr_ready, .o_wr_addr, .o_wr_data
);

// File: testbench/sfc_spi_master.sv
`timescale 1ns/1ns
module sfc_spi_master (
  input  wire logic i_sys_clk,
  input  wire logic i_so,
  input  wire logic i_so_oe,
  output logic      o_cs_b,
  output logic      o_sck,
  output logic      o_si
);
  // 160 ns link period at the 4 ns system clock
  localparam int HALF = 20;
  logic mode3;
  logic oe_seen;
  initial
  begin
    o_cs_b  = 1'b1;
    o_sck   = 1'b0;
    o_si    = 1'b0;
    mode3   = 1'b0;
    oe_seen = 1'b0;
  end
  always @(posedge i_sys_clk)
    if (i_so_oe)
      oe_seen <= 1'b1;
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask : wait_cyc
  // Clock parks at its idle level well before select so the mode is caught cleanly
  task automatic sel(input logic m3);
    wait_cyc(1);
    mode3 = m3;
    o_sck <= m3;
    wait_cyc(HALF);
    o_cs_b  <= 1'b0;
    oe_seen <= 1'b0;
    wait_cyc(HALF);
  endtask : sel
  task automatic shift(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--)
    begin
      o_sck <= 1'b0;
      o_si  <= tx[i];
      wait_cyc(HALF);
      o_sck <= 1'b1;
      // An undriven data line reads as the inverse, so a missing enable shows up as wrong data
      rx[i] = i_so_oe ? i_so : ~i_so;
      wait_cyc(HALF);
    end
  endtask : shift
  task automatic desel();
    o_sck <= mode3;
    wait_cyc(HALF);
    o_cs_b <= 1'b1;
    // Released data line flips so a stale level never passes for a sampled bit
    o_si <= ~o_si;
    wait_cyc(HALF);
  endtask : desel
endmodule : sfc_spi_master

// File: testbench/sfc_front_bench.sv
`timescale 1ns/1ns
module sfc_front_bench;
  import sfc_pkg::*;
  logic        i_sys_clk, i_rst_b, i_cs_b, i_sck, i_si, o_so, o_so_oe, o_spi_mode3, o_sleep;
  logic        o_wr_valid, i_wr_ready;
  logic [7:0]  o_status, i_rd_data, o_wr_data, sr, rx;
  logic [17:0] o_rd_addr, o_wr_addr, adr;
  logic [7:0]  txq [$];
  logic [7:0]  rxq [$];
  logic [7:0]  dat [11];
  int          fail_count, num_checks;

  sfc_front dut (
    .i_sys_clk, .i_rst_b, .i_cs_b, .i_sck, .i_si, .o_so, .o_so_oe, .o_spi_mode3, .o_sleep,
    .o_status, .o_rd_addr, .i_rd_data, .o_wr_valid, .i_wr_ready, .o_wr_addr, .o_wr_data
  );
  sfc_spi_master m (
    .i_sys_clk, .i_so(o_so), .i_so_oe(o_so_oe), .o_cs_b(i_cs_b), .o_sck(i_sck), .o_si(i_si)
  );
  initial
  begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  function automatic logic [7:0] rd_pattern(input logic [17:0] a);
    return a[7:0] ^ {a[17:12], 2'h3};
  endfunction : rd_pattern
  always @(posedge i_sys_clk)
    i_rd_data <= rd_pattern(o_rd_addr);
  task automatic chk_word(input logic [25:0] got, input logic [25:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    chk_word({18'h0, got}, {18'h0, exp});
  endtask : chk_byte
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  task automatic frame(input logic m3);
    logic [7:0] r;
    rxq = {};
    m.sel(m3);
    foreach (txq[i])
    begin
      m.shift(txq[i], 8, r);
      rxq.push_back(r);
    end
    m.desel();
  endtask : frame
  task automatic put_addr(input logic [5:0] up, input logic [17:0] a);
    txq.push_back({up, a[17:16]});
    txq.push_back(a[15:8]);
    txq.push_back(a[7:0]);
  endtask : put_addr
  initial
  begin
    i_rst_b    = 1'b0;
    i_wr_ready = 1'b0;
    i_rd_data  = 8'h00;
    fail_count = 0;
    num_checks = 0;
    rx = 8'($urandom(3566));
    repeat (10) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    @(posedge i_sys_clk);
    sr = SR_RESET;
    chk_byte(o_status, sr);
    chk_byte({6'h0, o_so_oe, o_wr_valid}, 8'h00);
    repeat (5) @(posedge i_sys_clk);
    for (int i = 0; i < 2; i++)
    begin
      txq = {OP_STATUS_READ, 8'h00, 8'h00};
      frame(i[0]);
      chk_byte(rxq[1], sr);
      chk_byte(rxq[2], sr);
      chk_byte({7'h0, o_spi_mode3}, {7'h0, i[0]});
    end
    // Partial opcode then refused writes: the latch must stay clear
    m.sel(1'b0);
    m.shift(OP_LATCH_SET, 7, rx);
    m.desel();
    txq = {OP_STATUS_WRITE, 8'h8C};
    frame(1'b1);
    txq = {OP_MEM_WRITE, 8'h00, 8'h00, 8'h10, 8'h5A};
    frame(1'b0);
    chk_byte(o_status, sr);
    chk_byte({7'h0, o_wr_valid}, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      txq = {OP_LATCH_SET};
      frame(1'($urandom));
      sr[SR_WE_FLAG_BIT] = 1'b1;
      chk_byte(o_status, sr);
      rx = (i == 0) ? 8'hFF : 8'($urandom);
      if (i == 1)
        txq = {OP_LATCH_CLEAR};
      else
        txq = {OP_STATUS_WRITE, rx};
      frame(1'($urandom));
      if (i != 1)
        sr = (sr & ~SR_WR_MASK) | (rx & SR_WR_MASK);
      sr[SR_WE_FLAG_BIT] = 1'b0;
      chk_byte(o_status, sr);
    end
    // Burst across the address wrap with the drain side stalled until the queue refuses
    txq = {OP_LATCH_SET};
    frame(1'b1);
    adr = 18'h3FFFC;
    txq = {OP_MEM_WRITE};
    put_addr(6'($urandom), adr);
    for (int i = 0; i < 11; i++)
    begin
      dat[i] = 8'($urandom);
      txq.push_back(dat[i]);
    end
    frame(1'b0);
    sr[SR_WE_FLAG_BIT] = 1'b0;
    chk_byte(o_status, sr);
    for (int i = 0; i < 9; i++)
    begin
      repeat ($urandom_range(4)) @(posedge i_sys_clk);
      for (int k = 0; k < 50 && o_wr_valid !== 1'b1; k++)
        @(posedge i_sys_clk);
      chk_word({o_wr_addr, o_wr_data}, {adr + 18'(i), dat[i]});
      i_wr_ready <= 1'b1;
      @(posedge i_sys_clk);
      i_wr_ready <= 1'b0;
      @(posedge i_sys_clk);
    end
    repeat (5) @(posedge i_sys_clk);
    chk_byte({7'h0, o_wr_valid}, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      adr = i ? 18'($urandom) : 18'h3FFFF;
      txq = {i ? OP_FAST_READ : OP_MEM_READ};
      put_addr(6'h00, adr);
      if (i)
        txq.push_back(8'h00);
      repeat (3) txq.push_back(8'($urandom));
      frame(1'($urandom));
      for (int k = 0; k < 3; k++)
        chk_byte(rxq[4 + i + k], rd_pattern(adr + 18'(k)));
    end
    for (int i = 0; i < 5; i++)
    begin
      rx = (i == 0) ? OP_SLEEP : (i == 1) ? OP_IDENT_READ : (i == 2) ? 8'hFF : 8'($urandom);
      while (rx inside {OP_LATCH_SET, OP_LATCH_CLEAR, OP_STATUS_READ, OP_STATUS_WRITE, OP_MEM_READ,
                        OP_FAST_READ, OP_MEM_WRITE})
        rx = 8'($urandom);
      txq = {rx, OP_STATUS_READ, 8'h00};
      frame(1'($urandom));
      chk_byte({7'h0, m.oe_seen}, 8'h00);
      chk_byte({7'h0, o_sleep}, {7'h0, rx == OP_SLEEP});
    end
    print_verdict();
  end
  // Whole sequence needs roughly 25k cycles
  initial
  begin
    repeat (80000) @(posedge i_sys_clk);
    fail_count++;
    print_verdict();
  end
endmodule : sfc_front_bench
